// ===== hdl/flash_bus_cycle.v
`timescale 1ns/1ps
`include "flash_host_defs.vh"

module flash_bus_cycle
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        clk_en_in,
  // Cycle request
  input  wire        start_in,
  input  wire        write_in,
  input  wire [14:0] addr_in,
  input  wire [7:0]  wdata_in,
  output reg         done_out,
  output reg  [7:0]  rdata_out,
  // Flash pins
  output reg         chip_select_n_out,
  output reg         output_gate_n_out,
  output reg         write_strobe_n_out,
  output reg  [14:0] addr_out,
  output reg  [7:0]  data_lines_out,
  output reg         data_lines_oe_n_out,
  input  wire [7:0]  data_lines_in
);

  localparam S_IDLE   = 3'd0;
  localparam S_SETUP  = 3'd1;
  localparam S_STROBE = 3'd2;
  localparam S_ACCESS = 3'd3;
  localparam S_HOLD   = 3'd4;

  localparam integer SETUP_I  = `SETUP_CYCLES - 1;
  localparam integer STROBE_I = `STROBE_CYCLES - 1;
  localparam integer ACCESS_I = `ACCESS_CYCLES - 1;
  localparam integer HOLD_I   = `HOLD_CYCLES - 1;

  // Counts are cut to the 8-bit counter on purpose
  localparam [7:0] SETUP_N  = SETUP_I[7:0];
  localparam [7:0] STROBE_N = STROBE_I[7:0];
  localparam [7:0] ACCESS_N = ACCESS_I[7:0];
  localparam [7:0] HOLD_N   = HOLD_I[7:0];

  reg [2:0] state;
  reg [7:0] cnt;
  reg       is_write;
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] sync3;
  reg [7:0] data_stable;

  // Pin data is asynchronous; accept a value only once two stages agree
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sync1       <= 8'h00;
      sync2       <= 8'h00;
      sync3       <= 8'h00;
      data_stable <= 8'h00;
    end
    else if (clk_en_in)
    begin
      sync1 <= data_lines_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3)
        data_stable <= sync3;
    end
  end

  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state               <= S_IDLE;
      cnt                 <= 8'h00;
      is_write            <= 1'b0;
      done_out            <= 1'b0;
      rdata_out           <= 8'h00;
      chip_select_n_out   <= 1'b1;
      output_gate_n_out   <= 1'b1;
      write_strobe_n_out  <= 1'b1;
      addr_out            <= 15'h0000;
      data_lines_out      <= 8'h00;
      data_lines_oe_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      done_out <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start_in)
          begin
            // Address stable before the strobe falls  // see R09
            addr_out          <= addr_in;
            is_write          <= write_in;
            chip_select_n_out <= 1'b0;
            if (write_in)
            begin
              data_lines_out      <= wdata_in;
              data_lines_oe_n_out <= 1'b0;
            end
            cnt   <= SETUP_N;
            state <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else if (is_write)
          begin
            write_strobe_n_out <= 1'b0; // see R09
            cnt                <= STROBE_N;
            state              <= S_STROBE;
          end
          else
          begin
            // Gate opens only inside chip select  // see R01
            output_gate_n_out <= 1'b0;
            cnt               <= ACCESS_N;
            state             <= S_ACCESS;
          end
        end
        S_STROBE:
        begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else
          begin
            // Data held past the rising edge  // see R09
            write_strobe_n_out <= 1'b1;
            cnt                <= HOLD_N;
            state              <= S_HOLD;
          end
        end
        S_ACCESS:
        begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else
          begin
            rdata_out         <= data_stable; // see R01
            output_gate_n_out <= 1'b1;
            cnt               <= HOLD_N;
            state             <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else
          begin
            chip_select_n_out   <= 1'b1;
            data_lines_oe_n_out <= 1'b1;
            done_out            <= 1'b1;
            state               <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

endmodule

// ===== hdl/flash_host_controller.v
// Overview of operation
// R01 - Data is read only while chip select and output gate are both low.
// R02 - Output gate high leaves the device's data lines floating.
// R03 - Chip select high puts the device in standby, outputs floating.
// R04 - Deselecting during erase, program or verify does not abort it.
// R05 - With supply low only array reads work; no verify or identify.
// R06 - Raised voltage on address nine reads maker at zero, part at one.
// R07 - After 90H, reads of address zero and one give maker and part.
// R08 - Identification is one command write then two reads.
// R09 - Write strobe pulses low under chip select; address at fall, data rise.
// R10 - The command register has no memory address.
// R11 - Supply low or rising leaves the register at 00H, reads only.
// R12 - Writing 00H selects array read until another command comes.
// R13 - Erase needs 20H then 20H again; one write only arms it.
// R14 - Erase runs from the second write's rise to the next write's rise.
// R15 - Erasing works only with the program supply at high voltage.
// R16 - Erase verify writes A0H with the address, then reads the result.
// R17 - Program writes 40H, then a write with address and byte.
// R18 - Program verify writes C0H then reads the last programmed byte.
// R19 - Reset is two FFH writes, followed by the next wanted command.
// R20 - A timed-out operation idles until a verify or reset command.
// R21 - Erase verify returns FFH only if all bits are erased.
// R22 - Program verify latches no new address.
// R23 - Undefined command codes change nothing and start nothing.
`timescale 1ns/1ps
`include "flash_host_defs.vh"

module flash_host_controller
#(
  parameter [23:0] ERASE_WAIT_CYCLES = `ERASE_WAIT_CYCLES
)
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        clk_en_in,
  // Operation request
  input  wire        start_in,
  input  wire [3:0]  op_in,
  input  wire [14:0] address_in,
  input  wire [7:0]  data_in,
  input  wire        supply_request_in,
  // Operation status
  output reg         busy_out,
  output reg         done_out,
  output reg         error_out,
  output reg  [15:0] result_out,
  // Flash pins
  output wire        chip_select_n_out,
  output wire        output_gate_n_out,
  output wire        write_strobe_n_out,
  output wire [14:0] addr_out,
  output wire [7:0]  data_lines_out,
  output wire        data_lines_oe_n_out,
  input  wire [7:0]  data_lines_in,
  output reg         id_high_voltage_out,
  output reg         program_supply_high_out
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_STEP  = 2'd1;
  localparam ST_BUS   = 2'd2;
  localparam ST_DELAY = 2'd3;

  localparam [23:0] PROG_WAIT = `PROG_WAIT_CYCLES;

  reg [1:0]  state;
  reg [3:0]  op_q;
  reg [14:0] addr_q;
  reg [7:0]  data_q;
  reg [2:0]  idx;
  reg [23:0] delay_cnt;
  reg        read_hi;
  reg        bus_start;
  reg        bus_write;
  reg [14:0] bus_addr;
  reg [7:0]  bus_wdata;
  wire       bus_done;
  wire [7:0] bus_rdata;

  // Step word: {user data, kind[1:0], addr select[1:0], data[7:0]}
  // Only defined codes appear, so no stray write can disturb the device
  function [12:0] step_of;
    input [3:0] op;
    input [2:0] i;
    begin
      step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
      case (op)
        `OP_READ_MODE:
          if (i == 3'd0) // see R12
            step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO, `CMD_READ_ARRAY};
        `OP_READ:
          if (i == 3'd0)
            step_of = {1'b0, `STEP_READ, `ASEL_USER, 8'h00};
        `OP_IDENT:
          case (i) // see R07, R08
            3'd0: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO, `CMD_IDENTIFY};
            3'd1: step_of = {1'b0, `STEP_READ, `ASEL_ZERO, 8'h00};
            3'd2: step_of = {1'b0, `STEP_READ, `ASEL_ONE, 8'h00};
            default: step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
          endcase
        `OP_IDENT_HV:
          case (i) // see R06
            3'd0: step_of = {1'b0, `STEP_READ, `ASEL_ZERO, 8'h00};
            3'd1: step_of = {1'b0, `STEP_READ, `ASEL_ONE, 8'h00};
            default: step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
          endcase
        `OP_ERASE:
          case (i) // see R13, R14, R16
            3'd0: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO, `CMD_ERASE};
            3'd1: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO, `CMD_ERASE};
            3'd2: step_of = {1'b0, `STEP_DELAY, `ASEL_ZERO, 8'h00};
            3'd3: step_of = {1'b0, `STEP_WRITE, `ASEL_USER,
                             `CMD_ERASE_VERIFY};
            3'd4: step_of = {1'b0, `STEP_READ, `ASEL_USER, 8'h00};
            default: step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
          endcase
        `OP_ERASE_VERIFY:
          case (i) // see R16, R21
            3'd0: step_of = {1'b0, `STEP_WRITE, `ASEL_USER,
                             `CMD_ERASE_VERIFY};
            3'd1: step_of = {1'b0, `STEP_READ, `ASEL_USER, 8'h00};
            default: step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
          endcase
        `OP_PROGRAM:
          case (i) // see R17, R18, R20
            3'd0: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO, `CMD_PROGRAM};
            3'd1: step_of = {1'b1, `STEP_WRITE, `ASEL_USER, 8'h00};
            3'd2: step_of = {1'b0, `STEP_DELAY, `ASEL_ZERO, 8'h00};
            3'd3: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO,
                             `CMD_PROGRAM_VERIFY};
            3'd4: step_of = {1'b0, `STEP_READ, `ASEL_USER, 8'h00};
            default: step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
          endcase
        `OP_PROGRAM_VERIFY:
          case (i) // see R18, R22
            3'd0: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO,
                             `CMD_PROGRAM_VERIFY};
            3'd1: step_of = {1'b0, `STEP_READ, `ASEL_USER, 8'h00};
            default: step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
          endcase
        `OP_RESET:
          case (i) // see R19
            3'd0: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO, `CMD_RESET};
            3'd1: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO, `CMD_RESET};
            3'd2: step_of = {1'b0, `STEP_WRITE, `ASEL_ZERO,
                             `CMD_READ_ARRAY};
            default: step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00};
          endcase
        default:
          step_of = {1'b0, `STEP_END, `ASEL_ZERO, 8'h00}; // see R23
      endcase
    end
  endfunction

  wire [12:0] step      = step_of(op_q, idx);
  wire        step_user = step[12];
  wire [1:0]  step_kind = step[11:10];
  wire [1:0]  step_asel = step[9:8];
  wire [7:0]  step_data = step[7:0];

  // Plain array reads and pin-voltage identify work at low supply
  wire needs_supply = (op_in != `OP_READ) && (op_in != `OP_IDENT_HV);

  wire [14:0] step_addr = (step_asel == `ASEL_USER) ? addr_q :
                          (step_asel == `ASEL_ONE)  ? `ID_PART_ADDR :
                                                      `ID_MAKER_ADDR;

  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state                   <= ST_IDLE;
      op_q                    <= `OP_READ_MODE;
      addr_q                  <= 15'h0000;
      data_q                  <= 8'h00;
      idx                     <= 3'd0;
      delay_cnt               <= 24'h000000;
      read_hi                 <= 1'b0;
      bus_start               <= 1'b0;
      bus_write               <= 1'b0;
      bus_addr                <= 15'h0000;
      bus_wdata               <= 8'h00;
      busy_out                <= 1'b0;
      done_out                <= 1'b0;
      error_out               <= 1'b0;
      result_out              <= 16'h0000;
      id_high_voltage_out     <= 1'b0;
      program_supply_high_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      done_out  <= 1'b0;
      error_out <= 1'b0;
      bus_start <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // Supply only switches between operations  // see R11
          program_supply_high_out <= supply_request_in;
          if (start_in)
          begin
            if (needs_supply && !program_supply_high_out)
            begin
              error_out <= 1'b1; // see R05, R15
              done_out  <= 1'b1;
            end
            else
            begin
              op_q                <= op_in;
              addr_q              <= address_in;
              data_q              <= data_in;
              idx                 <= 3'd0;
              read_hi             <= 1'b0;
              busy_out            <= 1'b1;
              id_high_voltage_out <= (op_in == `OP_IDENT_HV); // see R06
              state               <= ST_STEP;
            end
          end
        end
        ST_STEP:
        begin
          case (step_kind)
            `STEP_WRITE, `STEP_READ:
            begin
              // Command writes go out at address zero, except erase verify at the user address; see R10
              bus_start <= 1'b1;
              bus_write <= (step_kind == `STEP_WRITE);
              bus_addr  <= step_addr;
              bus_wdata <= step_user ? data_q : step_data;
              state     <= ST_BUS;
            end
            `STEP_DELAY:
            begin
              // Chip select stays high while it runs  // see R03, R04
              delay_cnt <= (op_q == `OP_ERASE) ?
                           ERASE_WAIT_CYCLES - 24'h000001 :
                           PROG_WAIT - 24'h000001;
              state     <= ST_DELAY;
            end
            default:
            begin
              busy_out            <= 1'b0;
              done_out            <= 1'b1;
              id_high_voltage_out <= 1'b0;
              state               <= ST_IDLE;
            end
          endcase
        end
        ST_BUS:
        begin
          if (bus_done)
          begin
            if (!bus_write)
            begin
              if (read_hi)
                result_out[15:8] <= bus_rdata;
              else
                result_out[7:0] <= bus_rdata;
              read_hi <= 1'b1;
            end
            idx   <= idx + 3'd1;
            state <= ST_STEP;
          end
        end
        ST_DELAY:
        begin
          if (delay_cnt == 24'h000000)
          begin
            idx   <= idx + 3'd1; // see R14
            state <= ST_STEP;
          end
          else
            delay_cnt <= delay_cnt - 24'h000001;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Output gate is released between cycles, so lines float  // see R02
  flash_bus_cycle u_bus
  (
    .clk_in              (clk_in),
    .reset_in            (reset_in),
    .clk_en_in           (clk_en_in),
    .start_in            (bus_start),
    .write_in            (bus_write),
    .addr_in             (bus_addr),
    .wdata_in            (bus_wdata),
    .done_out            (bus_done),
    .rdata_out           (bus_rdata),
    .chip_select_n_out   (chip_select_n_out),
    .output_gate_n_out   (output_gate_n_out),
    .write_strobe_n_out  (write_strobe_n_out),
    .addr_out            (addr_out),
    .data_lines_out      (data_lines_out),
    .data_lines_oe_n_out (data_lines_oe_n_out),
    .data_lines_in       (data_lines_in)
  );

endmodule

// ===== hdl/flash_host_defs.vh
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// Clock and bus timing, times in ns
`define CLK_PERIOD_NS 5
`define NS_TO_CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_SETUP_NS 20
`define T_STROBE_NS 60
`define T_HOLD_NS 20
`define T_ACCESS_NS 150
`define SYNC_CYCLES 3
`define SETUP_CYCLES `NS_TO_CYC_UP(`T_SETUP_NS)
`define STROBE_CYCLES `NS_TO_CYC_UP(`T_STROBE_NS)
`define HOLD_CYCLES `NS_TO_CYC_UP(`T_HOLD_NS)
`define ACCESS_CYCLES (`NS_TO_CYC_UP(`T_ACCESS_NS) + `SYNC_CYCLES)

// Program 10 us and erase 10 ms at 5 ns, sized for the 24-bit counter
`define PROG_WAIT_CYCLES 24'h0007D0
`define ERASE_WAIT_CYCLES 24'h1E8480

// Command codes
`define CMD_READ_ARRAY 8'h00
`define CMD_IDENTIFY 8'h90
`define CMD_ERASE 8'h20
`define CMD_ERASE_VERIFY 8'hA0
`define CMD_PROGRAM 8'h40
`define CMD_PROGRAM_VERIFY 8'hC0
`define CMD_RESET 8'hFF

// Identification addresses
`define ID_MAKER_ADDR 15'h0000
`define ID_PART_ADDR 15'h0001

// Host operations on op_in
`define OP_READ_MODE 4'h0
`define OP_READ 4'h1
`define OP_IDENT 4'h2
`define OP_IDENT_HV 4'h3
`define OP_ERASE 4'h4
`define OP_ERASE_VERIFY 4'h5
`define OP_PROGRAM 4'h6
`define OP_PROGRAM_VERIFY 4'h7
`define OP_RESET 4'h8

// Step kinds
`define STEP_END 2'h0
`define STEP_WRITE 2'h1
`define STEP_READ 2'h2
`define STEP_DELAY 2'h3

// Step address selects
`define ASEL_ZERO 2'h0
`define ASEL_ONE 2'h1
`define ASEL_USER 2'h2

`endif

// ===== tb/flash_device_model.sv
`timescale 1ns/1ps

module flash_device_model
#(
  parameter [7:0] MAKER_CODE = 8'h3C,
  parameter [7:0] PART_CODE  = 8'hC3
)
(
  // Strobes and levels
  input  wire        chip_select_n_in,
  input  wire        output_gate_n_in,
  input  wire        write_strobe_n_in,
  input  wire        supply_high_in,
  input  wire        id_voltage_in,
  // Address and data
  input  wire [14:0] addr_in,
  input  wire [7:0]  data_lines_in,
  output wire [7:0]  data_lines_out
);
  reg [7:0]  mem [0:32767];
  reg [7:0]  cmd;
  reg [7:0]  rd;
  reg [7:0]  held;
  reg [14:0] wa;
  reg [14:0] pa;
  reg [14:0] ea;
  reg        arm_erase;
  reg        arm_prog;
  reg        was_armed;
  integer    i;
  wire       drive = !chip_select_n_in && !output_gate_n_in;

  initial
  begin
    for (i = 0; i < 32768; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5A;
    cmd = 8'h00;
    arm_erase = 1'b0;
    arm_prog = 1'b0;
    held = 8'h00;
    pa = 15'h0000;
    ea = 15'h0000;
  end

  always @*
    if (id_voltage_in)
      rd = addr_in[0] ? PART_CODE : MAKER_CODE;
    else if (!supply_high_in)
      rd = mem[addr_in];
    else
      case (cmd)
        8'h90: rd = addr_in[0] ? PART_CODE : MAKER_CODE;
        8'hA0: rd = mem[ea];
        8'hC0: rd = mem[pa];
        default: rd = mem[addr_in];
      endcase

  // Released lines show the inverse so a stale value never passes
  always @*
    if (drive)
      held = rd;
  assign data_lines_out = drive ? rd : ~held;

  always @(negedge supply_high_in)
  begin
    cmd = 8'h00;
    arm_erase = 1'b0;
    arm_prog = 1'b0;
  end

  always @(negedge write_strobe_n_in)
    if (!chip_select_n_in)
      wa = addr_in;
  // Any address reaches the register; work ends instantly, so
  // a deselect never cuts it short and nothing runs on idle
  always @(posedge write_strobe_n_in)
    if (!chip_select_n_in && supply_high_in)
    begin
      was_armed = arm_erase;
      arm_erase = 1'b0;
      if (arm_prog)
      begin
        mem[wa] = data_lines_in;
        pa = wa;
        arm_prog = 1'b0;
      end
      else
        case (data_lines_in)
          8'h00, 8'h90, 8'hC0, 8'hFF: cmd = data_lines_in;
          8'hA0:
          begin
            cmd = 8'hA0;
            ea = wa;
          end
          8'h20:
            if (was_armed)
            begin
              for (i = 0; i < 32768; i = i + 1)
                mem[i] = 8'hFF;
              cmd = 8'h20;
            end
            else
              arm_erase = 1'b1;
          8'h40: arm_prog = 1'b1;
          default: ;
        endcase
    end
endmodule

// ===== tb/flash_host_checker_assertions.sv
`timescale 1ns/1ps
`include "flash_host_defs.vh"

module flash_host_checker
#(
  parameter [23:0] ERASE_WAIT_CYCLES = 24'd50
)
(
  // Clock and reset
  input wire        clk_in,
  input wire        reset_in,
  // Operation port
  input wire        start_in,
  input wire [3:0]  op_in,
  input wire        busy_out,
  input wire        done_out,
  input wire        error_out,
  // Flash pins
  input wire        chip_select_n_out,
  input wire        output_gate_n_out,
  input wire        write_strobe_n_out,
  input wire [14:0] addr_out,
  input wire [7:0]  data_lines_out,
  input wire        data_lines_oe_n_out,
  input wire        id_high_voltage_out,
  input wire        program_supply_high_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  chk_gate_under_select: assert property (
    !output_gate_n_out |-> !chip_select_n_out && data_lines_oe_n_out)
    else $error("output gate low outside a selected read");
  chk_strobe_under_select: assert property (
    !write_strobe_n_out |-> !chip_select_n_out && output_gate_n_out)
    else $error("write strobe low without chip select");
  chk_strobe_width: assert property (
    $fell(write_strobe_n_out) |-> ##11 !write_strobe_n_out
      ##1 write_strobe_n_out)
    else $error("write strobe width wrong");
  chk_write_steady: assert property (
    !write_strobe_n_out && $past(!write_strobe_n_out)
      |-> $stable(addr_out) && $stable(data_lines_out))
    else $error("address or data moved under the strobe");
  chk_data_at_rise: assert property (
    $rose(write_strobe_n_out) |-> !data_lines_oe_n_out
      && !chip_select_n_out)
    else $error("data not driven at strobe rise");
  chk_supply_for_write: assert property (
    !write_strobe_n_out |-> program_supply_high_out)
    else $error("command write without program supply");
  chk_refuse_no_supply: assert property (
    start_in && !busy_out && op_in == `OP_ERASE
      && !program_supply_high_out |-> ##[1:2] done_out && error_out)
    else $error("erase not refused without supply");
  chk_id_voltage_read: assert property (
    id_high_voltage_out |-> write_strobe_n_out)
    else $error("write while identification voltage raised");
  chk_idle_deselected: assert property (
    !busy_out |-> chip_select_n_out && write_strobe_n_out)
    else $error("device selected while idle");

  cover property ($fell(write_strobe_n_out));
  cover property (done_out && error_out);
  cover property (id_high_voltage_out && !output_gate_n_out);
endmodule

bind flash_host_controller flash_host_checker
#(
  .ERASE_WAIT_CYCLES(ERASE_WAIT_CYCLES)
)
u_flash_host_checker
(
  .clk_in(clk_in),
  .reset_in(reset_in),
  .start_in(start_in),
  .op_in(op_in),
  .busy_out(busy_out),
  .done_out(done_out),
  .error_out(error_out),
  .chip_select_n_out(chip_select_n_out),
  .output_gate_n_out(output_gate_n_out),
  .write_strobe_n_out(write_strobe_n_out),
  .addr_out(addr_out),
  .data_lines_out(data_lines_out),
  .data_lines_oe_n_out(data_lines_oe_n_out),
  .id_high_voltage_out(id_high_voltage_out),
  .program_supply_high_out(program_supply_high_out)
);

// ===== tb/flash_host_controller_bench.sv
`timescale 1ns/1ps
`include "flash_host_defs.vh"

module flash_host_controller_bench;
  localparam [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam [7:0] PART  = 8'hC3; // Arbitrary value
  reg        clk_in = 1'b0;
  reg        reset_in = 1'b1;
  reg        start_in = 1'b0;
  reg        supply_request_in = 1'b0;
  reg [3:0]  op_in = 4'h0;
  reg [14:0] address_in = 15'h0000;
  reg [7:0]  data_in = 8'h00;
  wire       busy_out, done_out, error_out, cs_n, og_n, we_n, oe_n, hv, vpp;
  wire [15:0] result_out;
  wire [14:0] addr_out;
  wire [7:0] host_dq, dev_dq;
  wire [7:0] data_lines_in = oe_n ? dev_dq : host_dq;
  integer    n_errors = 0;
  integer    n_tests = 0;
  integer    cycles = 0;
  reg [15:0] res;
  reg        err;

  always #2.5 clk_in = ~clk_in;

  flash_host_controller #(.ERASE_WAIT_CYCLES(24'd50)) u_flash_host_controller
  (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .start_in(start_in), .op_in(op_in), .address_in(address_in),
    .data_in(data_in), .supply_request_in(supply_request_in),
    .busy_out(busy_out), .done_out(done_out), .error_out(error_out),
    .result_out(result_out), .chip_select_n_out(cs_n),
    .output_gate_n_out(og_n), .write_strobe_n_out(we_n),
    .addr_out(addr_out), .data_lines_out(host_dq),
    .data_lines_oe_n_out(oe_n), .data_lines_in(data_lines_in),
    .id_high_voltage_out(hv), .program_supply_high_out(vpp)
  );

  flash_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART))
  u_flash_device_model
  (
    .chip_select_n_in(cs_n), .output_gate_n_in(og_n),
    .write_strobe_n_in(we_n), .supply_high_in(vpp),
    .id_voltage_in(hv), .addr_in(addr_out),
    .data_lines_in(data_lines_in), .data_lines_out(dev_dq)
  );

  task complete_run;
  begin
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  task check(input string what, input [15:0] got, input [15:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  // Hangs are cut by the cycle ceiling, not here
  task run_op(input [3:0] op, input [14:0] a, input [7:0] d);
  begin
    @(posedge clk_in);
    #1;
    start_in = 1'b1;
    op_in = op;
    address_in = a;
    data_in = d;
    @(posedge clk_in);
    #1;
    start_in = 1'b0;
    while (done_out !== 1'b1)
    begin
      @(posedge clk_in);
      #1;
    end
    res = result_out;
    err = error_out;
  end
  endtask

  task set_supply(input level);
  begin
    @(posedge clk_in);
    #1;
    supply_request_in = level;
    repeat (3) @(posedge clk_in);
  end
  endtask

  task t_supply_low;
  begin
    run_op(`OP_READ, 15'h1234, 8'h00);
    check("low read", {res[7:0], 7'h00, err}, {8'h34^8'h5A, 8'h00});
    run_op(`OP_IDENT, 15'h0000, 8'h00);
    check("low ident err", {15'h0, err}, 16'h0001);
    run_op(`OP_ERASE, 15'h0000, 8'h00);
    check("low erase err", {15'h0, err}, 16'h0001);
    run_op(`OP_PROGRAM, 15'h0010, 8'h00);
    check("low prog err", {15'h0, err}, 16'h0001);
    run_op(`OP_READ, 15'h0010, 8'h00);
    check("low intact", {8'h00, res[7:0]}, {8'h00, 8'h4A});
    run_op(`OP_IDENT_HV, 15'h0000, 8'h00);
    check("hv ident", res, {PART, MAKER});
  end
  endtask

  task t_ident_cmd;
  begin
    run_op(`OP_IDENT, 15'h0000, 8'h00);
    check("ident", {res[15:1], err}, {PART, MAKER[7:1], 1'b0});
    run_op(`OP_READ, 15'h0001, 8'h00);
    check("ident holds", {8'h00, res[7:0]}, {8'h00, PART});
    run_op(`OP_READ_MODE, 15'h0000, 8'h00);
    run_op(`OP_READ, 15'h0001, 8'h00);
    check("array read", {8'h00, res[7:0]}, 16'h005B);
  end
  endtask

  task t_program_erase;
  begin
    run_op(`OP_PROGRAM, 15'h0100, 8'hA5);
    check("prog verify", {7'h00, err, res[7:0]}, 16'h00A5);
    run_op(`OP_READ_MODE, 15'h0000, 8'h00);
    run_op(`OP_READ, 15'h0100, 8'h00);
    check("prog read", {8'h00, res[7:0]}, 16'h00A5);
    run_op(`OP_ERASE, 15'h0100, 8'h00);
    check("erase ok", {7'h00, err, res[7:0]}, 16'h00FF);
    run_op(`OP_READ_MODE, 15'h0000, 8'h00);
    run_op(`OP_READ, 15'h7FFF, 8'h00);
    check("erased read", {8'h00, res[7:0]}, 16'h00FF);
  end
  endtask

  task t_reset_undefined;
  begin
    run_op(`OP_PROGRAM, 15'h0200, 8'h3C);
    run_op(`OP_RESET, 15'h0000, 8'h00);
    check("reset err", {15'h0, err}, 16'h0000);
    run_op(`OP_READ, 15'h0200, 8'h00);
    check("after reset", {8'h00, res[7:0]}, 16'h003C);
    run_op(4'hF, 15'h0000, 8'h00);
    check("undefined op", {15'h0, err}, 16'h0000);
  end
  endtask

  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    t_supply_low;
    set_supply(1'b1);
    t_ident_cmd;
    t_program_erase;
    t_reset_undefined;
    complete_run;
  end
endmodule
